/* File: verilog/motor_guard.sv */
// Motor blocked, stall and thermal time-remaining monitor
`timescale 1ns/1ps
`include "motor_guard_regs.svh"

module motor_guard #(
    parameter int VAL_W = 16,
    parameter int SETTLE_CY = `MDS_SETTLE_S * `CLK_HZ
) (
    input  wire logic             i_ref_clk,
    input  wire logic             i_nrst,
    input  wire logic [7:0]       i_addr,
    input  wire logic [31:0]      i_wdata,
    input  wire logic             i_wr,
    input  wire logic             i_rd,
    output logic [31:0]           o_rdata,
    input  wire logic [VAL_W-1:0] i_speed_abs,
    input  wire logic             i_speed_ctrl_limited,
    input  wire logic             i_current_limited,
    input  wire logic [VAL_W-1:0] i_adapt_out_abs,
    input  wire logic [VAL_W-1:0] i_model_error,
    input  wire logic             i_thermal_alarm,
    input  wire logic [VAL_W-1:0] i_src_time [4],
    input  wire logic             i_mds_switch,
    output logic                  o_blocked_motor_fault,
    output logic                  o_motor_stalled_fault,
    output logic                  o_thermal_fault,
    output logic                  o_irq
);
    // ==============================================================
    // Register file
    logic [1:0]       ctrl_reg, ctrl_next;
    logic [3:0]       status_reg, status_next;
    logic [3:0]       mask_reg, mask_next;
    logic [VAL_W-1:0] blk_speed_reg, blk_speed_next;
    logic [31:0]      blk_delay_reg, blk_delay_next;
    logic [VAL_W-1:0] stall_speed_reg, stall_speed_next;
    logic [VAL_W-1:0] stall_err_reg, stall_err_next;
    logic [VAL_W-1:0] chg_speed_reg, chg_speed_next;
    logic [6:0]       chg_hyst_reg, chg_hyst_next;
    logic [31:0]      stall_delay_reg, stall_delay_next;
    logic [31:0]      rdata_reg, rdata_next;
    logic [15:0]      current_ctrl_status_word;
    logic [VAL_W-1:0] time_val;
    logic [VAL_W-1:0] diag_val [4];
    logic             time_valid;
    logic             blk_fire, stall_fire;
    logic [3:0]       events;

    // Synchronised loop inputs (they come from another block's pins)
    logic [VAL_W-1:0] spd_s1, spd_s2, adp_s1, adp_s2, err_s1, err_s2;
    logic [3:0]       flg_s1, flg_s2;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            spd_s1 <= '0;
            spd_s2 <= '0;
            adp_s1 <= '0;
            adp_s2 <= '0;
            err_s1 <= '0;
            err_s2 <= '0;
            flg_s1 <= 4'h0;
            flg_s2 <= 4'h0;
        end else begin
            spd_s1 <= i_speed_abs;
            spd_s2 <= spd_s1;
            adp_s1 <= i_adapt_out_abs;
            adp_s2 <= adp_s1;
            err_s1 <= i_model_error;
            err_s2 <= err_s1;
            flg_s1 <= {i_mds_switch, i_thermal_alarm,
                       i_current_limited, i_speed_ctrl_limited};
            flg_s2 <= flg_s1;
        end
    end

    // ==============================================================
    // Detection
    logic        vector_mode, mon_dis_n;
    logic        blocked_cond, speed_dev, stalled_bit;
    logic [31:0] hyst_limit;

    assign vector_mode = ctrl_reg[`CTRL_VECTOR_BIT];
    assign mon_dis_n   = ctrl_reg[`CTRL_MON_EN_N_BIT];

    // Speed below changeover speed scaled by (100% - hysteresis)
    function automatic logic [31:0] hyst_band(
        input logic [VAL_W-1:0] spd, input logic [6:0] pct);
        logic [6:0] rem;
        rem = (pct > 7'(`PCT_FULL)) ? 7'h00 : 7'(`PCT_FULL) - pct;
        return (32'(spd) * 32'(rem)) / 32'(`PCT_FULL);
    endfunction

    always_comb begin
        hyst_limit   = hyst_band(chg_speed_reg, chg_hyst_reg);
        blocked_cond = !mon_dis_n && (spd_s2 < blk_speed_reg) &&
                       (vector_mode ? flg_s2[0] : flg_s2[1]);
        speed_dev    = vector_mode &&
                       (adp_s2 > stall_speed_reg);
        stalled_bit  = vector_mode && (err_s2 > stall_err_reg) &&
                       (32'(spd_s2) < hyst_limit);
        current_ctrl_status_word = 16'h0000;
        current_ctrl_status_word[`CSW_SPEED_DEV_BIT] = speed_dev;
        current_ctrl_status_word[`CSW_STALLED_BIT]   = stalled_bit;
    end

    persist_timer #(.CNT_W(32)) u_blk_timer (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .i_cond    (blocked_cond),
        .i_delay   (blk_delay_reg),
        .o_fire    (blk_fire)
    );

    persist_timer #(.CNT_W(32)) u_stall_timer (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .i_cond    (speed_dev || stalled_bit),
        .i_delay   (stall_delay_reg),
        .o_fire    (stall_fire)
    );

    // Inputs are already the selected data set's margins
    time_remaining_calc #(
        .VAL_W     (VAL_W),
        .SETTLE_CY (SETTLE_CY)
    ) u_time (
        .i_ref_clk    (i_ref_clk),
        .i_nrst       (i_nrst),
        .i_src_time   (i_src_time),
        .i_mds_switch (flg_s2[3]),
        .o_time       (time_val),
        .o_diag       (diag_val),
        .o_valid      (time_valid)
    );

    // ==============================================================
    // Faults and interrupt
    logic fb_reg, fs_reg, ft_reg, irq_reg;
    logic valid_d_reg;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            fb_reg      <= 1'b0;
            fs_reg      <= 1'b0;
            ft_reg      <= 1'b0;
            irq_reg     <= 1'b0;
            // Idle level of valid, so reset makes no false rise
            valid_d_reg <= 1'b1;
        end else begin
            fb_reg      <= blk_fire;
            fs_reg      <= stall_fire;
            ft_reg      <= flg_s2[2];
            irq_reg     <= |(status_next & mask_next);
            valid_d_reg <= time_valid;
        end
    end

    assign events = {time_valid && !valid_d_reg, flg_s2[2],
                     stall_fire, blk_fire};

    assign o_blocked_motor_fault = fb_reg;
    assign o_motor_stalled_fault = fs_reg;
    assign o_thermal_fault       = ft_reg;
    assign o_irq                 = irq_reg;
    assign o_rdata               = rdata_reg;

    // ==============================================================
    // Bus slave
    always_comb begin
        ctrl_next        = ctrl_reg;
        mask_next        = mask_reg;
        blk_speed_next   = blk_speed_reg;
        blk_delay_next   = blk_delay_reg;
        stall_speed_next = stall_speed_reg;
        stall_err_next   = stall_err_reg;
        chg_speed_next   = chg_speed_reg;
        chg_hyst_next    = chg_hyst_reg;
        stall_delay_next = stall_delay_reg;
        rdata_next       = 32'h0000_0000;
        // Read clears, but a new event in the same cycle survives
        status_next = (i_rd && i_addr == `ADDR_STATUS) ? 4'h0
                                                       : status_reg;
        status_next = status_next | events;
        if (i_wr) begin
            unique case (i_addr)
                `ADDR_CTRL:        ctrl_next = i_wdata[1:0];
                `ADDR_MASK:        mask_next = i_wdata[3:0];
                `ADDR_BLK_SPEED:   blk_speed_next = i_wdata[VAL_W-1:0];
                `ADDR_BLK_DELAY:   blk_delay_next = i_wdata;
                `ADDR_STALL_SPEED: stall_speed_next = i_wdata[VAL_W-1:0];
                `ADDR_STALL_ERR:   stall_err_next = i_wdata[VAL_W-1:0];
                `ADDR_CHG_SPEED:   chg_speed_next = i_wdata[VAL_W-1:0];
                `ADDR_CHG_HYST:    chg_hyst_next = i_wdata[6:0];
                `ADDR_STALL_DELAY: stall_delay_next = i_wdata;
                default: ;
            endcase
        end
        if (i_rd) begin
            unique case (i_addr)
                `ADDR_CTRL:        rdata_next = 32'(ctrl_reg);
                `ADDR_STATUS:      rdata_next = 32'(status_reg);
                `ADDR_MASK:        rdata_next = 32'(mask_reg);
                `ADDR_BLK_SPEED:   rdata_next = 32'(blk_speed_reg);
                `ADDR_BLK_DELAY:   rdata_next = blk_delay_reg;
                `ADDR_STALL_SPEED: rdata_next = 32'(stall_speed_reg);
                `ADDR_STALL_ERR:   rdata_next = 32'(stall_err_reg);
                `ADDR_CHG_SPEED:   rdata_next = 32'(chg_speed_reg);
                `ADDR_CHG_HYST:    rdata_next = 32'(chg_hyst_reg);
                `ADDR_STALL_DELAY: rdata_next = stall_delay_reg;
                // Value meaningless until the settle delay ends
                `ADDR_TIME_REM:    rdata_next = {time_valid, 15'h0000,
                                                 16'(time_val)};
                `ADDR_DIAG_BASE:   rdata_next = 32'(diag_val[0]);
                8'h30:             rdata_next = 32'(diag_val[1]);
                8'h34:             rdata_next = 32'(diag_val[2]);
                8'h38:             rdata_next = 32'(diag_val[3]);
                `ADDR_CUR_STATUS:  rdata_next = 32'(current_ctrl_status_word);
                default:           rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_reg        <= 2'h0;
            status_reg      <= 4'h0;
            mask_reg        <= 4'h0;
            blk_speed_reg   <= '0;
            blk_delay_reg   <= 32'h0000_0000;
            stall_speed_reg <= '1;
            stall_err_reg   <= '1;
            chg_speed_reg   <= '0;
            chg_hyst_reg    <= 7'h00;
            stall_delay_reg <= 32'h0000_0000;
            rdata_reg       <= 32'h0000_0000;
        end else begin
            ctrl_reg        <= ctrl_next;
            status_reg      <= status_next;
            mask_reg        <= mask_next;
            blk_speed_reg   <= blk_speed_next;
            blk_delay_reg   <= blk_delay_next;
            stall_speed_reg <= stall_speed_next;
            stall_err_reg   <= stall_err_next;
            chg_speed_reg   <= chg_speed_next;
            chg_hyst_reg    <= chg_hyst_next;
            stall_delay_reg <= stall_delay_next;
            rdata_reg       <= rdata_next;
        end
    end

    // ==============================================================
    // Checks
    chk_thermal_no_delay: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        flg_s2[2] |=> o_thermal_fault)
        else $error("thermal fault delayed");
    chk_blocked_enable: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        mon_dis_n |-> ##2 !o_blocked_motor_fault)
        else $error("blocked detection while disabled");
    chk_stall_vector: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        !vector_mode |-> ##2 !o_motor_stalled_fault)
        else $error("stall detected outside vector control");
    chk_speed_dev: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        vector_mode && adp_s2 > stall_speed_reg
        |-> current_ctrl_status_word[11])
        else $error("speed deviation bit missing");
    chk_blocked_wait: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        $rose(blk_fire) && blk_delay_reg > 32'd1
        |-> $past(blocked_cond, 2))
        else $error("blocked fault before delay");
    chk_stall_fault: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        stall_fire |=> o_motor_stalled_fault)
        else $error("stall fault not issued");
    chk_irq_level: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        ##1 o_irq == |($past(status_next) & $past(mask_next)))
        else $error("irq does not follow status and mask");
endmodule

/* File: shared/motor_guard_regs.svh */
// Constants for the motor block and stall monitor
`ifndef MOTOR_GUARD_REGS_SVH
`define MOTOR_GUARD_REGS_SVH

// ==================================================================
// Register offsets
`define ADDR_CTRL          8'h00
`define ADDR_STATUS        8'h04
`define ADDR_MASK          8'h08
`define ADDR_BLK_SPEED     8'h0C
`define ADDR_BLK_DELAY     8'h10
`define ADDR_STALL_SPEED   8'h14
`define ADDR_STALL_ERR     8'h18
`define ADDR_CHG_SPEED     8'h1C
`define ADDR_CHG_HYST      8'h20
`define ADDR_STALL_DELAY   8'h24
`define ADDR_TIME_REM      8'h28
`define ADDR_DIAG_BASE     8'h2C
`define ADDR_CUR_STATUS    8'h3C

// ==================================================================
// Control fields
`define CTRL_MON_EN_N_BIT  0
`define CTRL_VECTOR_BIT    1

// Status fields (event bits)
`define ST_BLOCKED_BIT     0
`define ST_STALLED_BIT     1
`define ST_THERMAL_BIT     2
`define ST_MDS_VALID_BIT   3

// Current-controller status word bits
`define CSW_SPEED_DEV_BIT  11
`define CSW_STALLED_BIT    12

// ==================================================================
// Timing and limits
`define TIME_MAX_S         120
`define MDS_SETTLE_S       2
`define PCT_FULL           100
`define CLK_HZ             100000000

`endif

/* File: shared/motor_guard_pkg.sv */
// Types for the motor block and stall monitor
package motor_guard_pkg;
    typedef enum logic [1:0] {
        TMR_IDLE,
        TMR_RUN,
        TMR_FIRED
    } delay_state_t;
endpackage

/* File: verilog/persist_timer.sv */
// Persistence timer: fires once a condition has held for a delay
`timescale 1ns/1ps
module persist_timer #(
    parameter int CNT_W = 32
) (
    input  wire logic             i_ref_clk,
    input  wire logic             i_nrst,
    input  wire logic             i_cond,
    input  wire logic [CNT_W-1:0] i_delay,
    output logic                  o_fire
);
    motor_guard_pkg::delay_state_t state_reg;
    motor_guard_pkg::delay_state_t state_next;
    logic [CNT_W-1:0]              cnt_reg;
    logic [CNT_W-1:0]              cnt_next;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        unique case (state_reg)
            motor_guard_pkg::TMR_IDLE: begin
                cnt_next = '0;
                if (i_cond) begin
                    state_next = (i_delay == '0) ?
                        motor_guard_pkg::TMR_FIRED :
                        motor_guard_pkg::TMR_RUN;
                end
            end
            motor_guard_pkg::TMR_RUN: begin
                // Condition dropped early: start over from zero
                if (!i_cond) begin
                    state_next = motor_guard_pkg::TMR_IDLE;
                    cnt_next   = '0;
                end else if (cnt_reg + 1'b1 >= i_delay) begin
                    state_next = motor_guard_pkg::TMR_FIRED;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            motor_guard_pkg::TMR_FIRED: begin
                if (!i_cond) begin
                    state_next = motor_guard_pkg::TMR_IDLE;
                end
                cnt_next = '0;
            end
            default: begin
                state_next = motor_guard_pkg::TMR_IDLE;
                cnt_next   = '0;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_reg <= motor_guard_pkg::TMR_IDLE;
            cnt_reg   <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    assign o_fire = (state_reg == motor_guard_pkg::TMR_FIRED);

    chk_restart_on_drop: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        !i_cond |=> (cnt_reg == '0) && !o_fire)
        else $error("timer did not restart after condition dropped");
endmodule

/* File: verilog/time_remaining_calc.sv */
// Thermal time-remaining estimate with clamp and data-set settle delay
`timescale 1ns/1ps
`include "motor_guard_regs.svh"
module time_remaining_calc #(
    parameter int VAL_W     = 16,
    parameter int SETTLE_CY = `MDS_SETTLE_S * `CLK_HZ
) (
    input  wire logic             i_ref_clk,
    input  wire logic             i_nrst,
    input  wire logic [VAL_W-1:0] i_src_time [4],
    input  wire logic             i_mds_switch,
    output logic [VAL_W-1:0]      o_time,
    output logic [VAL_W-1:0]      o_diag [4],
    output logic                  o_valid
);
    localparam logic [VAL_W-1:0] TIME_MAX = VAL_W'(`TIME_MAX_S);

    logic [31:0]      settle_reg;
    logic [31:0]      settle_next;
    logic [VAL_W-1:0] min_val;

    // Smallest source margin sets the displayed value
    always_comb begin
        min_val = i_src_time[0];
        for (int k = 1; k < 4; k++) begin
            if (i_src_time[k] < min_val) begin
                min_val = i_src_time[k];
            end
        end
    end

    always_comb begin
        settle_next = settle_reg;
        if (i_mds_switch) begin
            settle_next = 32'(SETTLE_CY);
        end else if (settle_reg != 32'h0000_0000) begin
            settle_next = settle_reg - 32'h0000_0001;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            settle_reg <= 32'h0000_0000;
        end else begin
            settle_reg <= settle_next;
        end
    end

    always_comb begin
        o_time = (min_val > TIME_MAX) ? TIME_MAX : min_val;
        for (int k = 0; k < 4; k++) begin
            o_diag[k] = (i_src_time[k] > TIME_MAX) ? TIME_MAX
                                                   : i_src_time[k];
        end
        o_valid = (settle_reg == 32'h0000_0000);
    end

    chk_clamp_limit: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        o_time <= TIME_MAX)
        else $error("time remaining above clamp");
    chk_settle_hold: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        i_mds_switch |=> !o_valid)
        else $error("valid right after data set switch");
endmodule

/* File: dv/drive_loop_model.sv */
// Behavioural model of the drive's speed, current and thermal loops
`timescale 1ns/1ps
module drive_loop_model #(
    parameter int VAL_W = 16
) (
    input  wire logic        i_ref_clk,
    output logic [VAL_W-1:0] o_speed_abs,
    output logic             o_speed_ctrl_limited,
    output logic             o_current_limited,
    output logic [VAL_W-1:0] o_adapt_out_abs,
    output logic [VAL_W-1:0] o_model_error,
    output logic             o_thermal_alarm,
    output logic [VAL_W-1:0] o_src_time [4],
    output logic             o_mds_switch
);
    // ==========================================================
    // Loop outputs, moved only just after a clock edge
    initial begin
        o_speed_abs          = '1;
        o_speed_ctrl_limited = 1'b0;
        o_current_limited    = 1'b0;
        o_adapt_out_abs      = '0;
        o_model_error        = '0;
        o_thermal_alarm      = 1'b0;
        o_mds_switch         = 1'b0;
        for (int i = 0; i < 4; i++) begin
            o_src_time[i] = '1;
        end
    end

    task automatic drive(input logic [VAL_W-1:0] spd, input logic sl,
                         input logic il, input logic [VAL_W-1:0] adapt,
                         input logic [VAL_W-1:0] merr, input logic alarm);
        @(posedge i_ref_clk);
        o_speed_abs          <= spd;
        o_speed_ctrl_limited <= sl;
        o_current_limited    <= il;
        o_adapt_out_abs      <= adapt;
        o_model_error        <= merr;
        o_thermal_alarm      <= alarm;
    endtask

    // Configurer's thresholds are never raised here
    task automatic set_sources(input logic [VAL_W-1:0] t [4]);
        @(posedge i_ref_clk);
        for (int i = 0; i < 4; i++) begin
            o_src_time[i] <= t[i];
        end
    endtask

    task automatic switch_mds();
        @(posedge i_ref_clk);
        o_mds_switch <= 1'b1;
        @(posedge i_ref_clk);
        o_mds_switch <= 1'b0;
    endtask
endmodule

/* File: dv/testbench.sv */
// Self-checking testbench for the motor block and stall monitor
`timescale 1ns/1ps
`include "motor_guard_regs.svh"
module testbench;
    localparam int W = 16;
    localparam int SETTLE = 20;
    localparam int SPD_T = 500;
    localparam int ERR_T = 300;
    localparam int CHG = 1000;
    localparam int HYST = 10;
    logic         i_ref_clk = 1'b0;
    logic         i_nrst = 1'b0;
    logic [7:0]   i_addr = 8'h00;
    logic [31:0]  i_wdata = 32'h0;
    logic         i_wr = 1'b0;
    logic         i_rd = 1'b0;
    logic [31:0]  o_rdata;
    logic [W-1:0] spd, adapt, merr;
    logic [W-1:0] src [4];
    logic         slim, ilim, alarm, motor_data_set, o_irq;
    logic [2:0]   fault_vec;
    int           miscompares = 0;
    int           cmp_count = 0;

    always #5 i_ref_clk = ~i_ref_clk;

    drive_loop_model #(.VAL_W(W)) u_drive_loop_model (
        .i_ref_clk(i_ref_clk), .o_speed_abs(spd),
        .o_speed_ctrl_limited(slim), .o_current_limited(ilim),
        .o_adapt_out_abs(adapt), .o_model_error(merr),
        .o_thermal_alarm(alarm), .o_src_time(src), .o_mds_switch(motor_data_set));

    motor_guard #(.VAL_W(W), .SETTLE_CY(SETTLE)) u_motor_guard (
        .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_speed_abs(spd), .i_speed_ctrl_limited(slim),
        .i_current_limited(ilim), .i_adapt_out_abs(adapt),
        .i_model_error(merr), .i_thermal_alarm(alarm), .i_src_time(src),
        .i_mds_switch(motor_data_set), .o_blocked_motor_fault(fault_vec[0]),
        .o_motor_stalled_fault(fault_vec[1]),
        .o_thermal_fault(fault_vec[2]), .o_irq(o_irq));

    // ==========================================================
    // Checking and bus tasks
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        @(posedge i_ref_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        r = o_rdata;
    endtask

    // A rise before lo also fails, so an early fault is caught too
    task automatic watch(input int sel, input logic exp, input int lo,
                         input int hi, input string nm);
        int n;
        n = 0;
        while (n <= hi && fault_vec[sel] !== 1'b1) begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end
        check(nm, 32'(n <= hi && (n >= lo || !exp)), 32'(exp));
    endtask

    function automatic logic exp_blk(logic vec, logic dis, logic [W-1:0] s,
                                     logic [W-1:0] thr, logic sl, logic il);
        return !dis && s < thr && (vec ? sl : il);
    endfunction

    function automatic logic [1:0] exp_sw(logic vec, logic [W-1:0] a,
                                          logic [W-1:0] e, logic [W-1:0] s);
        if (!vec) return 2'b00;
        return {e > ERR_T && s * 100 < CHG * (100 - HYST), a > SPD_T};
    endfunction

    function automatic logic [W-1:0] clamp(logic [W-1:0] t);
        return (t > `TIME_MAX_S) ? W'(`TIME_MAX_S) : t;
    endfunction

    // ==========================================================
    // Scenarios
    initial begin
        logic [31:0]  r;
        logic [W-1:0] s, a, e, thr, tmin;
        logic [W-1:0] t [4];
        logic [1:0]   sw;
        logic         vec, sl, il;
        int           d, ds;
        void'($urandom(32'hB9C5));
        repeat (2) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        #1;
        check("faults at reset", {29'h0, fault_vec}, 32'h0);
        wr(8'hFC, 32'hFFFFFFFF);
        rd(8'hFC, r);
        check("unmapped read", r, 32'h0);
        rd(`ADDR_STATUS, r);
        check("status idle", r, 32'h0);
        thr = W'($urandom_range(200, 2000));
        d = $urandom_range(4, 12);
        wr(`ADDR_BLK_SPEED, 32'(thr));
        wr(`ADDR_BLK_DELAY, 32'(d));
        for (int k = 0; k < 10; k++) begin
            vec = k[0];
            sl = k[1] | k[3];
            il = k[2] | k[3];
            s = (k == 9) ? thr : W'($urandom_range(0, thr - 1));
            wr(`ADDR_CTRL, {30'h0, vec, k == 8});
            u_drive_loop_model.drive(s, sl, il, 16'h0, 16'h0, 1'b0);
            watch(0, exp_blk(vec, k == 8, s, thr, sl, il), d + 2, d + 6,
                  "blocked fault");
            u_drive_loop_model.drive(16'hFFFF, 1'b0, 1'b0, 16'h0, 16'h0, 1'b0);
            repeat (8) @(posedge i_ref_clk);
            #1;
            check("blocked drop", 32'(fault_vec[0]), 32'h0);
        end
        wr(`ADDR_CTRL, 32'h2);
        u_drive_loop_model.drive(16'h0, 1'b1, 1'b0, 16'h0, 16'h0, 1'b0);
        repeat (d - 2) @(posedge i_ref_clk);
        u_drive_loop_model.drive(16'h0, 1'b0, 1'b0, 16'h0, 16'h0, 1'b0);
        repeat (3) @(posedge i_ref_clk);
        u_drive_loop_model.drive(16'h0, 1'b1, 1'b0, 16'h0, 16'h0, 1'b0);
        watch(0, 1'b1, d + 2, d + 6, "blocked restart");
        ds = $urandom_range(3, 10);
        wr(`ADDR_STALL_SPEED, SPD_T);
        wr(`ADDR_STALL_ERR, ERR_T);
        wr(`ADDR_CHG_SPEED, CHG);
        wr(`ADDR_CHG_HYST, HYST);
        wr(`ADDR_STALL_DELAY, 32'(ds));
        for (int k = 0; k < 10; k++) begin
            vec = k < 8;
            a = (k[0] | k[3]) ? W'($urandom_range(SPD_T + 1, 4000))
                              : W'($urandom_range(0, SPD_T));
            e = (k[1] | k[3]) ? W'($urandom_range(ERR_T + 1, 4000))
                              : W'($urandom_range(0, ERR_T));
            s = (k[2] | k[3]) ? W'($urandom_range(0, 800))
                              : W'($urandom_range(1000, 3000));
            sw = exp_sw(vec, a, e, s);
            wr(`ADDR_CTRL, {30'h0, vec, 1'b1});
            u_drive_loop_model.drive(s, 1'b1, 1'b1, a, e, 1'b0);
            watch(1, |sw, ds + 2, ds + 6, "stall fault");
            rd(`ADDR_CUR_STATUS, r);
            check("status word", r & 32'h1800, {19'h0, sw, 11'h0});
            u_drive_loop_model.drive(16'hFFFF, 1'b0, 1'b0, 16'h0, 16'h0, 1'b0);
            repeat (8) @(posedge i_ref_clk);
            #1;
            check("stall drop", 32'(fault_vec[1]), 32'h0);
        end
        rd(`ADDR_STATUS, r);
        wr(`ADDR_MASK, 32'h0);
        for (int k = 0; k < 2; k++) begin
            u_drive_loop_model.drive(16'hFFFF, 1'b0, 1'b0, 16'h0, 16'h0, 1'b1);
            watch(2, 1'b1, 2, 5, "thermal fault");
            u_drive_loop_model.drive(16'hFFFF, 1'b0, 1'b0, 16'h0, 16'h0, 1'b0);
            repeat (6) @(posedge i_ref_clk);
            #1;
            check("irq level", 32'(o_irq), 32'(k));
            rd(`ADDR_STATUS, r);
            check("thermal event", r & 32'h4, 32'h4);
            @(posedge i_ref_clk);
            #1;
            check("irq after read", 32'(o_irq), 32'h0);
            wr(`ADDR_MASK, 32'h4);
        end
        for (int k = 0; k < 4; k++) begin
            for (int i = 0; i < 4; i++) begin
                t[i] = (k == 0) ? W'($urandom_range(121, 900))
                                : W'($urandom_range(0, 240));
            end
            u_drive_loop_model.set_sources(t);
            if (k == 3) begin
                u_drive_loop_model.switch_mds();
                repeat (SETTLE - 6) @(posedge i_ref_clk);
                rd(`ADDR_TIME_REM, r);
                check("settling", 32'(r[31]), 32'h0);
            end
            repeat (SETTLE) @(posedge i_ref_clk);
            tmin = t[0];
            for (int i = 1; i < 4; i++) begin
                tmin = (t[i] < tmin) ? t[i] : tmin;
            end
            rd(`ADDR_TIME_REM, r);
            check("time remaining", r & 32'h8000FFFF,
                  {1'b1, 15'h0, clamp(tmin)});
            for (int i = 0; i < 4; i++) begin
                rd(`ADDR_DIAG_BASE + 8'(4 * i), r);
                check("diag entry", r & 32'hFFFF, {16'h0, clamp(t[i])});
            end
        end
        rd(`ADDR_STATUS, r);
        check("valid event", r & 32'h8, 32'h8);
        test_done();
    end

    // Whole run is under a thousand cycles; this bound is far beyond it
    initial begin
        #600000;
        miscompares++;
        test_done();
    end
endmodule
